// >>> common/sad_map.vh
// address map constants for the secure alias address decoder
`ifndef SAD_MAP_VH
`define SAD_MAP_VH

`define SAD_SEC_BIT        28
`define SAD_DATA_BASE      32'h2000_0000
`define SAD_NSC_REGIONS    4
`define SAD_NSLAVE         11
`define SAD_SLV_W          4

// slave port codes, one per decoded target
`define SAD_SLV_FLASH      4'h0
`define SAD_SLV_BROM       4'h1
`define SAD_SLV_SRAMX      4'h2
`define SAD_SLV_SRAM0      4'h3
`define SAD_SLV_SRAM1      4'h4
`define SAD_SLV_SRAM2      4'h5
`define SAD_SLV_SRAM3      4'h6
`define SAD_SLV_APB        4'h7
`define SAD_SLV_AHB0       4'h8
`define SAD_SLV_AHB1       4'h9
`define SAD_SLV_AHB2       4'hA
`define SAD_SLV_NONE       4'hF

// non-secure views with bit 28 cleared: base and end of each target
`define SAD_FLASH_LO       32'h0000_0000
`define SAD_FLASH_HI       32'h0003_FFFF
`define SAD_BROM_LO        32'h0300_0000
`define SAD_BROM_HI        32'h0301_FFFF
`define SAD_SRAMX_LO       32'h0400_0000
`define SAD_SRAMX_HI       32'h0400_3FFF
`define SAD_SRAM0_LO       32'h2000_0000
`define SAD_SRAM0_HI       32'h2000_7FFF
`define SAD_SRAM1_LO       32'h2000_8000
`define SAD_SRAM1_HI       32'h2000_BFFF
`define SAD_SRAM2_LO       32'h2000_C000
`define SAD_SRAM2_HI       32'h2000_FFFF
`define SAD_SRAM3_LO       32'h2001_0000
`define SAD_SRAM3_HI       32'h2001_3FFF
`define SAD_APB_LO         32'h4000_0000
`define SAD_APB_HI         32'h4003_FFFF
`define SAD_AHB0_LO        32'h4008_0000
`define SAD_AHB0_HI        32'h4008_FFFF
`define SAD_AHB1_LO        32'h4009_0000
`define SAD_AHB1_HI        32'h4009_FFFF
`define SAD_AHB2_LO        32'h400A_0000
`define SAD_AHB2_HI        32'h400A_FFFF

`endif

// >>> dv/sad_checker_assertions.sv
// concurrent checks watching the matrix ports
`timescale 1ns/10ps
`default_nettype none
module sad_checker (
	input wire logic         i_clk,
	input wire logic         i_rst_b,
	input wire logic         i_m0_req,
	input wire logic         i_m1_req,
	input wire logic         i_m0_allow,
	input wire logic [31:0]  i_m0_addr,
	input wire logic [31:0]  i_m1_addr,
	input wire logic [127:0] i_nsc_base,
	input wire logic [127:0] i_nsc_limit,
	input wire logic [3:0]   i_nsc_en,
	input wire logic         o_m0_gnt,
	input wire logic         o_m1_gnt,
	input wire logic         o_m0_err,
	input wire logic         o_m0_code_bus,
	input wire logic         o_m0_secure,
	input wire logic         o_m0_nsc,
	input wire logic [10:0]  o_slv_sel
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// taken request and its region in the top address bits
	wire       tk  = i_m0_req && o_m0_gnt;
	wire       ok  = tk && i_m0_allow;
	wire [2:0] top = i_m0_addr[31:29];
	sequence s_split; i_m0_req && i_m1_req && top == 3'h0 && i_m1_addr[31:29] == 3'h1; endsequence
	sequence s_wait; i_m1_req && !o_m1_gnt; endsequence
	property p_bus; tk |=> o_m0_code_bus == ($past(top) == 3'h0); endproperty
	property p_sec; tk |=> o_m0_secure == $past(i_m0_addr[28]); endproperty
	property p_flash; ok && top == 3'h0 && i_m0_addr[27:18] == 0 |=> o_slv_sel[0]; endproperty
	property p_sram; ok && top == 3'h1 && i_m0_addr[27:15] == 0 |=> o_slv_sel[3]; endproperty
	property p_periph; ok && top == 3'h2 && i_m0_addr[27:18] == 0 |=> o_slv_sel[7]; endproperty
	property p_hole; tk && top == 3'h3 |=> o_m0_err; endproperty
	property p_deny; tk && !i_m0_allow |=> o_m0_err && !o_slv_sel[3]; endproperty
	property p_both; s_split |-> o_m0_gnt && o_m1_gnt; endproperty
	property p_rr; s_wait ##1 i_m1_req |-> o_m1_gnt; endproperty
	property p_nsc; i_nsc_en[0] && i_m0_addr[28] && i_m0_addr >= i_nsc_base[31:0]
		&& i_m0_addr <= i_nsc_limit[31:0] |-> o_m0_nsc; endproperty
	a_bus: assert property (p_bus) else $error("bus choice wrong");
	a_sec: assert property (p_sec) else $error("security view wrong");
	a_flash: assert property (p_flash) else $error("flash not selected");
	a_sram: assert property (p_sram) else $error("sram not selected");
	a_periph: assert property (p_periph) else $error("bridge not selected");
	a_hole: assert property (p_hole) else $error("no error on hole");
	a_deny: assert property (p_deny) else $error("refusal ignored");
	a_both: assert property (p_both) else $error("split ports stalled");
	a_rr: assert property (p_rr) else $error("loser starved");
	a_nsc: assert property (p_nsc) else $error("callable area missed");
endmodule
`default_nettype wire

// >>> dv/sad_master_model.sv
// far-side bus master: holds its request and address until granted
`timescale 1ns/10ps
`default_nettype none
module sad_master_model (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_go,
	input  wire logic [31:0] i_addr,
	input  wire logic        i_gnt,
	output logic             o_req,
	output logic [31:0]      o_addr
);
	// released address is inverted so a stale value never looks valid
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_req  <= 1'b0;
			o_addr <= 32'h0000_0000;
		end else if (o_req && i_gnt) begin
			o_req  <= 1'b0;
			o_addr <= ~o_addr;
		end else if (i_go && !o_req && !({i_addr[31:29], i_addr[27:18]} == 0 && i_addr[17:0] >= 18'h3_D000)) begin
			o_req  <= 1'b1;
			o_addr <= i_addr;
		end
	end
endmodule
`default_nettype wire

// >>> dv/tb_secure_alias_address_decoder.sv
// self-checking bench for the secure alias decoder matrix
`timescale 1ns/10ps
`default_nettype none
module tb_secure_alias_address_decoder;
	logic i_clk = 1'b0, i_rst_b = 1'b0, i_m0_req = 1'b0, i_m0_allow = 1'b1, i_m1_allow = 1'b1, go = 1'b0;
	logic [31:0] i_m0_addr = 32'h0000_0000, ga = 32'h0000_0000;
	logic [127:0] i_nsc_base = 128'h0, i_nsc_limit = 128'h0;
	logic [3:0] i_nsc_en = 4'h0;
	wire i_m1_req, o_m0_gnt, o_m1_gnt, o_m0_err, o_m1_err, o_m0_code_bus, o_m1_code_bus;
	wire o_m0_secure, o_m1_secure, o_m0_nsc, o_m1_nsc;
	wire [31:0] i_m1_addr;
	wire [10:0] o_slv_sel, o_slv_owner;
	int fail_count = 0, total_checks = 0;
	logic w;
	// slave code in the top nibble, address below
	logic [35:0] map [13] = '{{4'h0, 32'h0000_0000}, {4'h0, 32'h1003_FFFF}, {4'h1, 32'h1300_0000},
		{4'h2, 32'h0400_3FFF}, {4'h3, 32'h3000_0004}, {4'h4, 32'h2000_8000}, {4'h5, 32'h3000_FFFF},
		{4'h6, 32'h2001_0000}, {4'h7, 32'h5002_0000}, {4'h8, 32'h4008_0000}, {4'h9, 32'h5009_FFFF},
		{4'hA, 32'h400A_0000}, {4'hF, 32'h6000_0000}};
	always #12.5 i_clk = ~i_clk;
	sad_matrix dut (
		.i_clk         (i_clk),
		.i_rst_b       (i_rst_b),
		.i_m0_req      (i_m0_req),
		.i_m0_addr     (i_m0_addr),
		.o_m0_gnt      (o_m0_gnt),
		.o_m0_err      (o_m0_err),
		.o_m0_code_bus (o_m0_code_bus),
		.o_m0_secure   (o_m0_secure),
		.i_m1_req      (i_m1_req),
		.i_m1_addr     (i_m1_addr),
		.o_m1_gnt      (o_m1_gnt),
		.o_m1_err      (o_m1_err),
		.o_m1_code_bus (o_m1_code_bus),
		.o_m1_secure   (o_m1_secure),
		.i_m0_allow    (i_m0_allow),
		.i_m1_allow    (i_m1_allow),
		.i_nsc_base    (i_nsc_base),
		.i_nsc_limit   (i_nsc_limit),
		.i_nsc_en      (i_nsc_en),
		.o_m0_nsc      (o_m0_nsc),
		.o_m1_nsc      (o_m1_nsc),
		.o_slv_sel     (o_slv_sel),
		.o_slv_owner   (o_slv_owner)
	);
	sad_master_model peer (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_go(go), .i_addr(ga),
		.i_gnt(o_m1_gnt), .o_req(i_m1_req), .o_addr(i_m1_addr));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		if (got !== exp) begin
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
		total_checks++;
	endtask
	// one master-0 transfer; outputs are looked at the half cycle after the take
	task req0(input logic [31:0] a);
		@(negedge i_clk);
		i_m0_req = 1'b1;
		i_m0_addr = a;
		#1 chk(o_m0_gnt, 1'b1);
		@(negedge i_clk);
		i_m0_req = 1'b0;
		i_m0_addr = ~a;
	endtask
	task t_map;
		logic [31:0] a;
		for (int i = 0; i < 13; i++) begin
			a = map[i][31:0];
			req0(a);
			chk(o_slv_sel, map[i][35:32] == 4'hF ? 11'h000 : 11'h001 << map[i][35:32]);
			chk(o_m0_err, map[i][35:32] == 4'hF);
			chk(o_m0_code_bus, a < 32'h2000_0000);
			chk(o_m0_secure, a[28]);
		end
		$display("map test done");
	endtask
	task t_deny;
		i_m0_allow = 1'b0;
		req0(32'h3000_0000);
		chk({o_m0_err, o_slv_sel}, 12'h800);
		i_m0_allow = 1'b1;
		$display("deny test done");
	endtask
	// same port: one waits a cycle; different ports: both proceed
	task t_pair;
		@(negedge i_clk);
		go = 1'b1;
		ga = 32'h4000_0010;
		@(negedge i_clk);
		go = 1'b0;
		i_m0_req = 1'b1;
		i_m0_addr = 32'h4000_0000;
		#1 w = o_m1_gnt;
		chk(o_m0_gnt ^ o_m1_gnt, 1'b1);
		@(negedge i_clk);
		if (!w) i_m0_req = 1'b0;
		chk({o_slv_sel[7], o_slv_owner[7]}, {1'b1, w});
		chk(w ? o_m0_gnt : o_m1_gnt, 1'b1);
		@(negedge i_clk);
		i_m0_req = 1'b0;
		chk({o_slv_sel[7], o_slv_owner[7]}, {1'b1, !w});
		go = 1'b1;
		ga = 32'h2000_0000;
		@(negedge i_clk);
		go = 1'b0;
		i_m0_req = 1'b1;
		i_m0_addr = 32'h0000_0100;
		#1 chk({o_m0_gnt, o_m1_gnt}, 2'h3);
		@(negedge i_clk);
		i_m0_req = 1'b0;
		chk(o_slv_sel, 11'h009);
		chk({o_m0_code_bus, o_m1_code_bus, o_m1_secure, o_m1_err}, 4'h8);
		$display("pair test done");
	endtask
	// peer refused by attribution: granted at once, error answer, no port taken
	task t_peer;
		i_m1_allow = 1'b0;
		i_nsc_base[63:32] = 32'h3000_0000;
		i_nsc_limit[63:32] = 32'h3000_0FFF;
		i_nsc_en = 4'h2;
		go = 1'b1;
		ga = 32'h3000_0010;
		@(negedge i_clk);
		go = 1'b0;
		chk({i_m1_req, o_m1_gnt, o_m1_nsc}, 3'h7);
		@(negedge i_clk);
		chk({o_m1_err, o_m1_secure, o_m1_code_bus, o_slv_sel[3]}, 4'hC);
		i_m1_allow = 1'b1;
		i_nsc_en = 4'h0;
		$display("peer test done");
	endtask
	task t_nsc;
		i_nsc_base[31:0] = 32'h1000_0000;
		i_nsc_limit[31:0] = 32'h1000_0FFF;
		i_nsc_en = 4'h1;
		for (int i = 0; i < 3; i++) begin
			@(negedge i_clk);
			i_m0_addr = i == 0 ? 32'h1000_0100 : i == 1 ? 32'h0000_0100 : 32'h1000_1000;
			#1 chk(o_m0_nsc, i == 0);
		end
		i_nsc_en = 4'h0;
		$display("callable test done");
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge i_clk);
		@(negedge i_clk);
		i_rst_b = 1'b1;
		t_map;
		t_deny;
		t_pair;
		t_peer;
		t_nsc;
		summarize;
	end
	// watchdog well beyond the few dozen cycles the tests need
	initial begin
		#(25 * 3000);
		fail_count++;
		summarize;
	end
endmodule
bind sad_matrix sad_checker u_chk (
	.i_clk         (i_clk),
	.i_rst_b       (i_rst_b),
	.i_m0_req      (i_m0_req),
	.i_m1_req      (i_m1_req),
	.i_m0_allow    (i_m0_allow),
	.i_m0_addr     (i_m0_addr),
	.i_m1_addr     (i_m1_addr),
	.i_nsc_base    (i_nsc_base),
	.i_nsc_limit   (i_nsc_limit),
	.i_nsc_en      (i_nsc_en),
	.o_m0_gnt      (o_m0_gnt),
	.o_m1_gnt      (o_m1_gnt),
	.o_m0_err      (o_m0_err),
	.o_m0_code_bus (o_m0_code_bus),
	.o_m0_secure   (o_m0_secure),
	.o_m0_nsc      (o_m0_nsc),
	.o_slv_sel     (o_slv_sel)
);
`default_nettype wire

// >>> rtl/sad_matrix.v
// address decoder and per-slave arbiter for a two-master secure-alias bus matrix
// Overview of operation
// - code-region addresses up to 0x1FFFFFFF go out on the code bus.
// - addresses from 0x20000000 to the top go out on the system bus.
// - address bit 28 marks an access secure when set, non-secure when clear.
// - slave selection ignores bit 28, so every location answers at two addresses.
// - secure base is non-secure base with bit 28 set; both reach one slave.
// - first 256 MB is non-secure code memory; next 256 MB the same, secure.
// - data SRAM at 0x20000000 non-secure, at 0x30000000 secure.
// - peripherals at 0x40000000 non-secure and at 0x50000000 secure.
// - masters on different slave ports proceed together; same port is arbitrated.
// - permission, including non-secure callable, comes from separate attribution input.
// - attribution may mark chosen secure sub-areas non-secure callable.
//
// timing in brief: a grant is combinational in the request cycle, while the
// port select, owner, error, bus and view answers are registered and stand
// for exactly one cycle after the edge that took the request.
// a master that loses a tie must hold its request and address; round robin
// per port hands it the next cycle, so the wait is never longer than one.
// an unmapped or refused access is granted at once and answered with an
// error, so a stray pointer costs one cycle instead of a hung master.
// bit 28 is stripped before the range match, which is why the alias view
// needs no second copy of the address table.
// the callable flags stay combinational: the attribution logic judges the
// address in the cycle it is presented, and a register would make it late.
// permission is never decided here; the allow inputs only steer the error path.
// limitation: two masters only; a third layer needs a wider priority scheme.
// limitation: the reserved top of flash is decoded like the rest of flash,
// keeping off it is the masters' duty.
`timescale 1ns/10ps
`default_nettype none
`include "sad_map.vh"

module sad_matrix (
	input  wire                          i_clk,
	input  wire                          i_rst_b,
	// master 0 request and answer
	input  wire                          i_m0_req,
	input  wire [31:0]                   i_m0_addr,
	output wire                          o_m0_gnt,
	output reg                           o_m0_err,
	output reg                           o_m0_code_bus,
	output reg                           o_m0_secure,
	// master 1 request and answer
	input  wire                          i_m1_req,
	input  wire [31:0]                   i_m1_addr,
	output wire                          o_m1_gnt,
	output reg                           o_m1_err,
	output reg                           o_m1_code_bus,
	output reg                           o_m1_secure,
	// attribution verdict for each master, from separate logic
	input  wire                          i_m0_allow,
	input  wire                          i_m1_allow,
	// non-secure callable windows, from the attribution logic
	input  wire [`SAD_NSC_REGIONS*32-1:0] i_nsc_base,
	input  wire [`SAD_NSC_REGIONS*32-1:0] i_nsc_limit,
	input  wire [`SAD_NSC_REGIONS-1:0]    i_nsc_en,
	output wire                          o_m0_nsc,
	output wire                          o_m1_nsc,
	// slave side: one select per port and the owning master
	output reg  [`SAD_NSLAVE-1:0]        o_slv_sel,
	output reg  [`SAD_NSLAVE-1:0]        o_slv_owner
);

	// per-master decode results
	wire                  m0_code;
	wire                  m1_code;
	wire                  m0_sec;
	wire                  m1_sec;
	wire [`SAD_SLV_W-1:0] m0_slv;
	wire [`SAD_SLV_W-1:0] m1_slv;
	// arbitration state and per-port request vectors
	reg  [`SAD_NSLAVE-1:0] prio;   // per slave: 1 means master 1 wins next tie
	wire [`SAD_NSLAVE-1:0] req0;
	wire [`SAD_NSLAVE-1:0] req1;
	wire [`SAD_NSLAVE-1:0] win0;
	wire [`SAD_NSLAVE-1:0] win1;
	// callable hits and failure terms
	wire [`SAD_NSC_REGIONS-1:0] hit0;
	wire [`SAD_NSC_REGIONS-1:0] hit1;
	wire                  m0_unmapped;
	wire                  m1_unmapped;
	wire                  m0_fail;
	wire                  m1_fail;
	// next-state terms
	wire [`SAD_NSLAVE-1:0] contend;      // both masters want the same port
	wire [`SAD_NSLAVE-1:0] next_prio;
	wire [`SAD_NSLAVE-1:0] next_sel;
	wire [`SAD_NSLAVE-1:0] next_owner;
	reg                   next_m0_err;
	reg                   next_m1_err;
	reg                   next_m0_code;
	reg                   next_m1_code;
	reg                   next_m0_sec;
	reg                   next_m1_sec;

	// master 0 layer: bus, view and port decode, all combinational
	sad_slave_decode u_dec0 (
		.i_addr     (i_m0_addr),
		.o_code_bus (m0_code),
		.o_secure   (m0_sec),
		.o_slave    (m0_slv)
	);

	// master 1 layer, an identical copy so the layers never share a decoder
	sad_slave_decode u_dec1 (
		.i_addr     (i_m1_addr),
		.o_code_bus (m1_code),
		.o_secure   (m1_sec),
		.o_slave    (m1_slv)
	);

	// an address that no port claims is answered on the error path
	assign m0_unmapped = (m0_slv == `SAD_SLV_NONE);
	assign m1_unmapped = (m1_slv == `SAD_SLV_NONE);

	// the decoder never judges permission; that verdict arrives from outside
	assign m0_fail     = m0_unmapped | ~i_m0_allow;
	assign m1_fail     = m1_unmapped | ~i_m1_allow;

	// callable windows only apply inside the secure view
	genvar g;
	generate
		for (g = 0; g < `SAD_NSC_REGIONS; g = g + 1) begin : g_nsc
			// bounds are inclusive at both ends; a window whose limit lies
			// below its base never hits, so an unused entry can be parked
			assign hit0[g] = i_nsc_en[g] & m0_sec &
				(i_m0_addr >= i_nsc_base[g*32 +: 32]) &
				(i_m0_addr <= i_nsc_limit[g*32 +: 32]);
			assign hit1[g] = i_nsc_en[g] & m1_sec &
				(i_m1_addr >= i_nsc_base[g*32 +: 32]) &
				(i_m1_addr <= i_nsc_limit[g*32 +: 32]);
		end
	endgenerate
	assign o_m0_nsc = |hit0;
	assign o_m1_nsc = |hit1;

	// per-port arbitration; different ports never block each other
	generate
		for (g = 0; g < `SAD_NSLAVE; g = g + 1) begin : g_arb
			// a request reaches a port only when it decodes there and is permitted
			assign req0[g]       = i_m0_req & ~m0_fail & (m0_slv == g);
			assign req1[g]       = i_m1_req & ~m1_fail & (m1_slv == g);
			assign contend[g]    = req0[g] & req1[g];
			// a lone requester always wins; a tie goes where prio points
			assign win0[g]       = req0[g] & (~req1[g] | ~prio[g]);
			assign win1[g]       = req1[g] & (~req0[g] | prio[g]);
			// the tie loser goes first next time, so neither master starves
			assign next_prio[g]  = prio[g] ^ contend[g];
			assign next_sel[g]   = win0[g] | win1[g];
			assign next_owner[g] = win1[g];
		end
	endgenerate

	// error requests are granted at once so a bad address never hangs a master
	assign o_m0_gnt = i_m0_req & (m0_fail | (|win0));
	assign o_m1_gnt = i_m1_req & (m1_fail | (|win1));

	// master 0 answer terms; an error is owed for every failing request,
	// since a failing request is always granted
	always @* begin
		next_m0_err  = i_m0_req & m0_fail;
		next_m0_code = m0_code;
		next_m0_sec  = m0_sec;
	end

	// master 1 answer terms, built the same way as master 0
	always @* begin
		next_m1_err  = i_m1_req & m1_fail;
		next_m1_code = m1_code;
		next_m1_sec  = m1_sec;
	end

	// tie-break state, one bit per port; reset hands master 0 the first tie
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prio <= {`SAD_NSLAVE{1'b0}};
		end else begin
			prio <= next_prio;
		end
	end

	// slave side: select and owner answer one cycle after the grant edge
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_slv_sel   <= {`SAD_NSLAVE{1'b0}};
			o_slv_owner <= {`SAD_NSLAVE{1'b0}};
		end else begin
			// owner is only meaningful where the matching select bit is set
			o_slv_sel   <= next_sel;
			o_slv_owner <= next_owner;
		end
	end

	// master 0 answers, recomputed every edge so each stands one cycle
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_m0_err      <= 1'b0;
			o_m0_code_bus <= 1'b0;
			o_m0_secure   <= 1'b0;
		end else begin
			// bus and view follow the address even in a cycle without a request
			o_m0_err      <= next_m0_err;
			o_m0_code_bus <= next_m0_code;
			o_m0_secure   <= next_m0_sec;
		end
	end

	// master 1 answers, recomputed every edge so each stands one cycle
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_m1_err      <= 1'b0;
			o_m1_code_bus <= 1'b0;
			o_m1_secure   <= 1'b0;
		end else begin
			// bus and view follow the address even in a cycle without a request
			o_m1_err      <= next_m1_err;
			o_m1_code_bus <= next_m1_code;
			o_m1_secure   <= next_m1_sec;
		end
	end

endmodule
`default_nettype wire

// >>> rtl/sad_slave_decode.v
// one master layer: bus choice, security view and slave select for one address
`timescale 1ns/10ps
`default_nettype none
`include "sad_map.vh"

module sad_slave_decode (
	input  wire [31:0]               i_addr,
	output reg                       o_code_bus,
	output reg                       o_secure,
	output reg  [`SAD_SLV_W-1:0]     o_slave
);

	reg [31:0] phys;

	// bit 28 picks the view only; the select below never looks at it
	always @* begin
		o_code_bus = (i_addr < `SAD_DATA_BASE);
		o_secure   = i_addr[`SAD_SEC_BIT];
		phys       = i_addr & ~(32'h0000_0001 << `SAD_SEC_BIT);
		if (phys <= `SAD_FLASH_HI)
			o_slave = `SAD_SLV_FLASH;
		else if (phys >= `SAD_BROM_LO && phys <= `SAD_BROM_HI)
			o_slave = `SAD_SLV_BROM;
		else if (phys >= `SAD_SRAMX_LO && phys <= `SAD_SRAMX_HI)
			o_slave = `SAD_SLV_SRAMX;
		else if (phys >= `SAD_SRAM0_LO && phys <= `SAD_SRAM0_HI)
			o_slave = `SAD_SLV_SRAM0;
		else if (phys >= `SAD_SRAM1_LO && phys <= `SAD_SRAM1_HI)
			o_slave = `SAD_SLV_SRAM1;
		else if (phys >= `SAD_SRAM2_LO && phys <= `SAD_SRAM2_HI)
			o_slave = `SAD_SLV_SRAM2;
		else if (phys >= `SAD_SRAM3_LO && phys <= `SAD_SRAM3_HI)
			o_slave = `SAD_SLV_SRAM3;
		else if (phys >= `SAD_APB_LO && phys <= `SAD_APB_HI)
			o_slave = `SAD_SLV_APB;
		else if (phys >= `SAD_AHB0_LO && phys <= `SAD_AHB0_HI)
			o_slave = `SAD_SLV_AHB0;
		else if (phys >= `SAD_AHB1_LO && phys <= `SAD_AHB1_HI)
			o_slave = `SAD_SLV_AHB1;
		else if (phys >= `SAD_AHB2_LO && phys <= `SAD_AHB2_HI)
			o_slave = `SAD_SLV_AHB2;
		else
			o_slave = `SAD_SLV_NONE;
	end

endmodule
`default_nettype wire
